// ### hw/ppl_defines.svh
// ppl_defines.svh: offsets, field positions, codes and reset values of the guard
// assumes byte addressing on a 32-bit Avalon-MM slave
`ifndef PPL_DEFINES_SVH
`define PPL_DEFINES_SVH
`define PPL_OFS_LEVEL   5'h00
`define PPL_OFS_PWENT   5'h04
`define PPL_OFS_CHECK   5'h08
`define PPL_OFS_CLEAR   5'h0C
`define PPL_OFS_STATUS  5'h10
`define PPL_NOLOCK      14'h270F
`define PPL_PW_MIN      14'h03E8
`define PPL_PW_MAX      14'h270E
`define PPL_LVL_GRP     14'h0063
`define PPL_LVL_CNT     14'h0064
`define PPL_LVL_GRPC    14'h00C7
`define PPL_FAIL_MAX    3'h5
`define PPL_ALLCLR_A    16'h9966
`define PPL_ALLCLR_B    16'h55AA
`define PPL_PCLR_A      16'h9696
`define PPL_PCLR_B      16'h5A5A
`define PPL_CHK_SRC     1:0
`define PPL_CHK_WR      2
`define PPL_CHK_GRP     3
`define PPL_CHK_RDOFF   4
`define PPL_CHK_WROFF   5
`define PPL_CHK_KIND    8:6
`define PPL_CLR_CODE    15:0
`define PPL_CLR_SRC     17:16
`endif

// ### hw/ppl_pkg.sv
// ppl_pkg: types shared by the parameter password guard
// assumes ppl_defines.svh supplies the numeric layout
package ppl_pkg;
    typedef enum logic [1:0] {
        PPL_SRC_PANEL  = 2'h0,
        PPL_SRC_RS485  = 2'h1,
        PPL_SRC_OPTION = 2'h2
    } ppl_src_t;
    typedef enum logic [2:0] {
        PPL_K_NORMAL   = 3'h0,
        PPL_K_LEVEL    = 3'h1,
        PPL_K_PWENT    = 3'h2,
        PPL_K_CONTRAST = 3'h3,
        PPL_K_INTERNAL = 3'h4
    } ppl_kind_t;
    typedef struct packed {
        ppl_kind_t kind;
        logic      wr_off;
        logic      rd_off;
        logic      in_group;
        logic      is_write;
        ppl_src_t  src;
    } ppl_check_t;
    typedef enum logic [1:0] {
        PPL_ST_IDLE = 2'h0,
        PPL_ST_DATA = 2'h1,
        PPL_ST_DONE = 2'h2
    } ppl_bus_t;
endpackage : ppl_pkg

// ### hw/ppl_guard.sv
// ppl_guard: password guard for the parameter store, Avalon-MM register slave
// assumes one 100 MHz clock, requests synchronous, master holds until waitrequest low
`timescale 1ns/1ns
`include "ppl_defines.svh"
module ppl_guard (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        drive_running,
    input  wire logic        option_fitted,
    input  wire logic        panel_unit,
    output logic             option_fault,
    output logic             lock_display,
    output logic             jog_screen_off,
    output logic             copy_allowed,
    output logic             params_erase,
    output logic             params_clear
);
    logic        rst_s1_r;
    logic        rst_sync_n;
    logic [13:0] level_r;
    logic [13:0] pw_r;
    logic        pw_set_r;
    logic [2:0]  fail_r;
    logic [9:0]  chk_r;
    logic        verdict_r;
    logic        clr_ok_r;
    ppl_pkg::ppl_bus_t st_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // base level with the counting hundred removed
    function automatic logic [13:0] base_of(input logic [13:0] l);
        base_of = (l >= `PPL_LVL_CNT && l != `PPL_NOLOCK) ? l - `PPL_LVL_CNT : l;
    endfunction : base_of

    // {panel rd, panel wr, rs485 rd, rs485 wr, option rd, option wr}
    function automatic logic [5:0] matrix(input logic [13:0] b);
        case (b)
            14'h0000: matrix = 6'h00;
            14'h0001: matrix = 6'h2A;
            14'h0002: matrix = 6'h2F;
            14'h0003: matrix = 6'h3A;
            14'h0004: matrix = 6'h02;
            14'h0005: matrix = 6'h0F;
            14'h0006: matrix = 6'h32;
            default:  matrix = 6'h3F;
        endcase
    endfunction : matrix

    function automatic logic level_ok(input logic [13:0] l);
        logic [13:0] b;
        b = base_of(l);
        level_ok = l == `PPL_NOLOCK || b <= 14'h0006 || b == `PPL_LVL_GRP;
    endfunction : level_ok

    wire logic [13:0] base      = base_of(level_r);
    wire logic        counting  = level_r >= `PPL_LVL_CNT && level_r != `PPL_NOLOCK;
    wire logic        locked    = counting && fail_r == `PPL_FAIL_MAX;
    wire logic [2:0]  fail_show = counting ? fail_r : 3'h0;

    wire logic        req       = avs_read | avs_write;
    wire logic        take      = req & ~avs_waitrequest;
    wire logic        wr_take   = take & avs_write & (&avs_byteenable[1:0]);
    wire logic [13:0] wval      = avs_writedata[13:0];
    wire logic        wr_level  = wr_take && avs_address == `PPL_OFS_LEVEL;
    wire logic        wr_pw     = wr_take && avs_address == `PPL_OFS_PWENT;
    wire logic        wr_chk    = wr_take && avs_address == `PPL_OFS_CHECK;
    wire logic        wr_clr    = wr_take && avs_address == `PPL_OFS_CLEAR;

    // access verdict for the request held in the check register
    ppl_pkg::ppl_check_t ck;
    assign ck = ppl_pkg::ppl_check_t'(chk_r[8:0]);
    wire logic [13:0] eff_base  = (base == `PPL_LVL_GRP) ? 14'h0004 : base;
    wire logic [5:0]  mx        = matrix(eff_base);
    wire logic [2:0]  sel       = {ck.src, ck.is_write};
    // the unused source code shifts every permission out, so the matrix refuses it
    wire logic [5:0]  mx_sh     = mx << sel;
    wire logic        mx_ok     = mx_sh[5];
    wire logic        net_src   = ck.src != ppl_pkg::PPL_SRC_PANEL;
    wire logic        grp_pass  = base == `PPL_LVL_GRP && ck.in_group;
    wire logic        pw_kind   = ck.kind == ppl_pkg::PPL_K_LEVEL
                                  || ck.kind == ppl_pkg::PPL_K_PWENT;
    wire logic        spec_ok   = ck.kind == ppl_pkg::PPL_K_INTERNAL
                                  || (ck.kind == ppl_pkg::PPL_K_CONTRAST && panel_unit);
    wire logic        pw_allow  = !pw_set_r || mx_ok || grp_pass || spec_ok || pw_kind;
    wire logic        sel_block = ck.is_write ? ck.wr_off
                                  : (ck.rd_off && !net_src);
    wire logic        kind_blk  = ck.is_write &&
                                  ((ck.kind == ppl_pkg::PPL_K_LEVEL && pw_set_r) ||
                                   (ck.kind == ppl_pkg::PPL_K_PWENT &&
                                    level_r == `PPL_NOLOCK));
    wire logic        allow     = pw_allow && !sel_block && !kind_blk;

    // clear commands
    wire logic [15:0] code      = avs_writedata[`PPL_CLR_CODE];
    wire logic        opt_clr   = avs_writedata[`PPL_CLR_SRC] == ppl_pkg::PPL_SRC_OPTION;
    wire logic        is_all    = code == `PPL_ALLCLR_A || code == `PPL_ALLCLR_B;
    wire logic        is_pclr   = code == `PPL_PCLR_A || code == `PPL_PCLR_B;
    wire logic        all_go    = wr_clr && is_all && !drive_running;
    wire logic        pclr_go   = wr_clr && is_pclr && (!pw_set_r || opt_clr);

    // password entry write
    wire logic        pw_valid  = wval >= `PPL_PW_MIN && wval <= `PPL_PW_MAX;
    wire logic        pw_ok_wr  = wr_pw && level_r != `PPL_NOLOCK;
    wire logic        pw_reg    = pw_ok_wr && !pw_set_r && pw_valid;
    wire logic        pw_try    = pw_ok_wr && pw_set_r;
    wire logic        pw_match  = pw_try && !locked && wval == pw_r;
    wire logic        pw_miss   = pw_try && !locked && wval != pw_r;
    wire logic        unlock    = pw_match || all_go || (pclr_go && pw_set_r);

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            level_r  <= `PPL_NOLOCK;
            pw_r     <= `PPL_NOLOCK;
            pw_set_r <= 1'b0;
            fail_r   <= 3'h0;
        end else begin
            if (all_go)
                level_r <= `PPL_NOLOCK;
            else if (wr_level && !pw_set_r && level_ok(wval))
                level_r <= wval;
            if (pw_reg)
                pw_r <= wval;
            if (unlock)
                pw_set_r <= 1'b0;
            else if (pw_reg)
                pw_set_r <= 1'b1;
            if (unlock)
                fail_r <= 3'h0;
            else if (pw_miss && counting)
                fail_r <= fail_r + 3'h1;
        end
    end

    // the held request is re-evaluated every cycle so the verdict follows lock changes
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chk_r     <= 10'h000;
            verdict_r <= 1'b0;
            clr_ok_r  <= 1'b0;
        end else begin
            if (wr_chk)
                chk_r <= {1'b1, avs_writedata[8:0]};
            verdict_r <= allow;
            if (wr_clr)
                clr_ok_r <= all_go || pclr_go;
        end
    end

    // bus: one wait cycle, read data registered in it, action on the release edge
    wire logic [31:0] rd_mux =
        avs_address == `PPL_OFS_LEVEL  ? {18'h0, level_r} :
        avs_address == `PPL_OFS_PWENT  ? (pw_set_r ? {29'h0, fail_show}
                                                   : {18'h0, `PPL_NOLOCK}) :
        avs_address == `PPL_OFS_CHECK  ? {21'h0, verdict_r, chk_r} :
        avs_address == `PPL_OFS_STATUS ? {26'h0, clr_ok_r, fail_show, locked, pw_set_r} :
        32'h0000_0000;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r            <= ppl_pkg::PPL_ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            case (st_r)
                ppl_pkg::PPL_ST_IDLE: begin
                    if (req) begin
                        st_r            <= ppl_pkg::PPL_ST_DATA;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                end
                ppl_pkg::PPL_ST_DATA: begin
                    st_r            <= ppl_pkg::PPL_ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    st_r            <= ppl_pkg::PPL_ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // outputs; lock display only for refusals caused by the password itself
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            option_fault   <= 1'b0;
            lock_display   <= 1'b0;
            jog_screen_off <= 1'b0;
            copy_allowed   <= 1'b1;
            params_erase   <= 1'b0;
            params_clear   <= 1'b0;
        end else begin
            option_fault   <= level_r != `PPL_NOLOCK && base == 14'h0000
                              && option_fitted;
            lock_display   <= chk_r[9] && !pw_allow;
            jog_screen_off <= level_r != `PPL_NOLOCK &&
                              (base == 14'h0004 || base == 14'h0005);
            copy_allowed   <= !pw_set_r;
            params_erase   <= all_go;
            params_clear   <= pclr_go;
        end
    end

    sequence s_miss_at_four;
        counting && pw_miss && fail_r == 3'h4 && !unlock;
    endsequence
    sequence s_reg_write;
        pw_reg && !unlock;
    endsequence

    property p_lock_fifth;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s_miss_at_four |=> locked;
    endproperty
    a_lock_fifth: assert property (p_lock_fifth) else $error("no lock at fifth miss");

    property p_locked_holds;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        locked && !all_go && !(pclr_go && pw_set_r) |=> locked;
    endproperty
    a_locked_holds: assert property (p_locked_holds) else $error("lock released");

    property p_register;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s_reg_write |=> pw_set_r && pw_r == $past(wval);
    endproperty
    a_register: assert property (p_register) else $error("password not stored");

    property p_nolock_pw;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        level_r == `PPL_NOLOCK && !pw_set_r && !all_go |=> !pw_set_r;
    endproperty
    a_nolock_pw: assert property (p_nolock_pw) else $error("entry at level 9999");

    property p_level_frozen;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        pw_set_r && !all_go |=> $stable(level_r);
    endproperty
    a_level_frozen: assert property (p_level_frozen) else $error("level changed");

    property p_zero_count;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !counting |-> fail_r == 3'h0 && fail_show == 3'h0;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("count shown");

    property p_all_clear;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        all_go |=> !pw_set_r && fail_r == 3'h0 && params_erase ##1 !params_erase;
    endproperty
    a_all_clear: assert property (p_all_clear) else $error("all clear failed");

    property p_run_block;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        wr_clr && is_all && drive_running |=> !params_erase;
    endproperty
    a_run_block: assert property (p_run_block) else $error("all clear while running");

    property p_pclr_src;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        wr_clr && is_pclr && pw_set_r && !opt_clr |=> !params_clear && pw_set_r;
    endproperty
    a_pclr_src: assert property (p_pclr_src) else $error("parameter clear accepted");

    property p_copy;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        pw_set_r |=> !copy_allowed;
    endproperty
    a_copy: assert property (p_copy) else $error("copy allowed while registered");

    property p_read_sel;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ck.rd_off && !ck.is_write && !net_src |=> !verdict_r;
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("read allowed");

    property p_write_sel;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ck.wr_off && ck.is_write |=> !verdict_r;
    endproperty
    a_write_sel: assert property (p_write_sel) else $error("write allowed");

    property p_fault;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        level_r == 14'h0064 && option_fitted |=> option_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("no option fault");

    property p_match_unlock;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        pw_match |=> !pw_set_r && fail_r == 3'h0;
    endproperty
    a_match_unlock: assert property (p_match_unlock) else $error("match kept lock");

    property p_miss_keeps;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        pw_miss |=> pw_set_r;
    endproperty
    a_miss_keeps: assert property (p_miss_keeps) else $error("mismatch unlocked");

    property p_pwent_read;
        @(posedge sys_clk) disable iff (!rst_sync_n)
        st_r == ppl_pkg::PPL_ST_IDLE && avs_read && pw_set_r
        && avs_address == `PPL_OFS_PWENT |=> avs_readdata <= 32'h0000_0005;
    endproperty
    a_pwent_read: assert property (p_pwent_read) else $error("entry read leaks");

endmodule : ppl_guard

// ### sim/ppl_host.sv
// ppl_host: avalon-mm master standing in for panel, network and option
// assumes one clock and a slave that answers by dropping waitrequest
`timescale 1ns/1ns
module ppl_host (
    input  wire logic        sys_clk,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end
    // held until waitrequest is seen low; no answer time is assumed
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // released data is inverted so a stale word is never mistaken for a live one
        avs_writedata <= ~d;
    endtask : xfer
endmodule : ppl_host

// ### sim/tb_top.sv
// tb_top: self-checking bench for the parameter password guard
// assumes ppl_host as the bus master and the guard's register layout
`timescale 1ns/1ns
`include "ppl_defines.svh"
module tb_top;
    logic        sys_clk, rst_n, bus_rd, bus_wr, waitreq, drive_running, option_fitted;
    logic        panel_unit, option_fault, lock_display, jog_screen_off, copy_allowed;
    logic        params_erase, params_clear, m, g, ro, wo;
    logic [4:0]  addr;
    logic [3:0]  ben;
    logic [31:0] wdata, rdata, q, pw;
    int          n_fail, n_checks, seed, n_erase, n_clear, e0;
    int          lv[16] = '{0, 1, 2, 3, 4, 5, 6, 99, 100, 101, 102, 103, 104, 105, 106, 199};
    logic [15:0] codes[4] = '{16'h9696, 16'h5A5A, 16'h9966, 16'h55AA};
    ppl_guard u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(addr),
        .avs_read(bus_rd), .avs_write(bus_wr), .avs_writedata(wdata), .avs_byteenable(ben),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .drive_running(drive_running),
        .option_fitted(option_fitted), .panel_unit(panel_unit),
        .option_fault(option_fault), .lock_display(lock_display),
        .jog_screen_off(jog_screen_off), .copy_allowed(copy_allowed),
        .params_erase(params_erase), .params_clear(params_clear));
    ppl_host u_host (.sys_clk(sys_clk), .avs_address(addr), .avs_read(bus_rd),
        .avs_write(bus_wr), .avs_writedata(wdata), .avs_byteenable(ben),
        .avs_readdata(rdata), .avs_waitrequest(waitreq));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (params_erase === 1'b1) n_erase <= n_erase + 1;
        if (params_clear === 1'b1) n_clear <= n_clear + 1;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        u_host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // {panel r,w, rs485 r,w, option r,w} for the level's base pattern
    function automatic logic allow(input int lvl, input int src, input logic w,
                                   input logic grp);
        logic [5:0] t;
        int         l;
        l = lvl % 100;
        if (l == 99) l = grp ? 7 : 4;
        case (l)
            0: t = 6'h00;
            1: t = 6'h2A;
            2: t = 6'h2F;
            3: t = 6'h3A;
            4: t = 6'h02;
            5: t = 6'h0F;
            6: t = 6'h32;
            default: t = 6'h3F;
        endcase
        return t[5 - (src * 2 + int'(w))];
    endfunction : allow
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        complete_run();
    end
    initial begin
        seed = 63;
        {n_fail, n_checks, n_erase, n_clear} = '0;
        rst_n = 1'b0;
        {drive_running, option_fitted} = 2'h0;
        panel_unit = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("copy_allowed", 32'(copy_allowed), 32'h1);
        rd(`PPL_OFS_LEVEL);
        chk("level", q, 32'h270F);
        rd(5'h14);
        chk("unmapped", q, 32'h0);
        wr(`PPL_OFS_PWENT, 32'h04D2);
        rd(`PPL_OFS_PWENT);
        chk("pwent", q, 32'h270F);
        wr(`PPL_OFS_LEVEL, 32'h1);
        wr(`PPL_OFS_PWENT, 32'h03E7);
        rd(`PPL_OFS_STATUS);
        chk("below_range", 32'(q[0]), 32'h0);
        wr(`PPL_OFS_PWENT, 32'h270E);
        wr(`PPL_OFS_LEVEL, 32'h2);
        rd(`PPL_OFS_LEVEL);
        chk("level_frozen", q, 32'h1);
        chk("copy_blocked", 32'(copy_allowed), 32'h0);
        wr(`PPL_OFS_PWENT, 32'h0007);
        wr(`PPL_OFS_PWENT, 32'h0007);
        rd(`PPL_OFS_PWENT);
        chk("count_zero", q, 32'h0);
        wr(`PPL_OFS_PWENT, 32'h270E);
        rd(`PPL_OFS_STATUS);
        chk("unlock", 32'(q[0]), 32'h0);
        for (int i = 0; i < 16; i++) begin
            option_fitted <= 1'($random(seed));
            panel_unit    <= 1'($random(seed));
            pw = 32'h03E8 + ($unsigned($random(seed)) % 32'h2327);
            wr(`PPL_OFS_LEVEL, 32'(lv[i]));
            wr(`PPL_OFS_PWENT, pw);
            chk("jog_off", 32'(jog_screen_off), 32'(lv[i] % 100 inside {4, 5}));
            chk("opt_fault", 32'(option_fault), 32'(lv[i] % 100 == 0 && option_fitted));
            for (int k = 0; k < 6; k++) begin
                {g, ro, wo} = 3'($random(seed));
                wr(`PPL_OFS_CHECK, {23'h0, 3'h0, wo, ro, g, 1'(k % 2), 2'(k / 2)});
                rd(`PPL_OFS_CHECK);
                m = allow(lv[i], k / 2, 1'(k % 2), g);
                chk("verdict", 32'(q[10]), 32'(m && !((k % 2) ? wo : (ro && k < 2))));
                chk("lock_display", 32'(lock_display), 32'(!m));
            end
            // level read, level write, contrast read from panel, internal write from rs485
            foreach (codes[j]) begin
                wr(`PPL_OFS_CHECK, {23'h0, 3'(j + int'(j != 1)), 3'h0, 1'(j % 2), 2'(j / 3)});
                rd(`PPL_OFS_CHECK);
                m = (j == 2) ? (panel_unit || allow(lv[i], 0, 1'b0, 1'b0)) : (j != 1);
                chk("kind", 32'(q[10]), 32'(m));
            end
            wr(`PPL_OFS_PWENT, pw);
            rd(`PPL_OFS_STATUS);
            chk("unlocked", 32'(q[0]), 32'h0);
        end
        wr(`PPL_OFS_LEVEL, 32'h65);
        wr(`PPL_OFS_PWENT, 32'h07D0);
        for (int n = 1; n <= 5; n++) begin
            wr(`PPL_OFS_PWENT, 32'h07D1);
            rd(`PPL_OFS_PWENT);
            chk("fail_count", q, 32'(n));
        end
        wr(`PPL_OFS_PWENT, 32'h07D0);
        rd(`PPL_OFS_STATUS);
        chk("latched", 32'(q[1:0]), 32'h3);
        e0 = n_clear;
        wr(`PPL_OFS_CLEAR, {14'h0, 2'h0, 16'h9696});
        wr(`PPL_OFS_CLEAR, {14'h0, 2'h1, 16'h5A5A});
        drive_running <= 1'b1;
        wr(`PPL_OFS_CLEAR, {14'h0, 2'h0, 16'h9966});
        rd(`PPL_OFS_STATUS);
        chk("clear_refused", 32'(q[5:0]), 32'h17);
        chk("no_clear", 32'(n_clear - e0), 32'h0);
        drive_running <= 1'b0;
        e0 = n_erase;
        wr(`PPL_OFS_CLEAR, {14'h0, 2'h1, 16'h55AA});
        rd(`PPL_OFS_STATUS);
        chk("all_clear", 32'(q[5:0]), 32'h20);
        chk("erase", 32'(n_erase - e0), 32'h1);
        rd(`PPL_OFS_LEVEL);
        chk("level_reset", q, 32'h270F);
        foreach (codes[j]) begin
            wr(`PPL_OFS_LEVEL, 32'h66);
            wr(`PPL_OFS_PWENT, 32'h1388);
            e0 = n_clear;
            wr(`PPL_OFS_CLEAR, {14'h0, 2'h2, codes[j]});
            rd(`PPL_OFS_STATUS);
            chk("option_clear", 32'(q[5:0]), 32'h20);
            chk("pclr_pulse", 32'(n_clear - e0), 32'(j < 2));
        end
        complete_run();
    end
endmodule : tb_top
